/* File: tb.sv */
// self-checking bench for the timer
`timescale 1ns/10ps
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, a); \
  miscompares++; end end
module tb;
  typedef struct {logic [2:0] sel; logic pol; logic [15:0] pw, rl;} tpc_row_t;
  tpc_row_t rows[4] = '{'{3'h0, 1'b0, 16'h0002, 16'h0003},
    '{3'h1, 1'b1, 16'h0003, 16'h0008}, '{3'h2, 1'b0, 16'h0002, 16'h0004},
    '{3'h0, 1'b1, 16'h0005, 16'h0006}};
  logic core_clk = 1'b0, rst_n = 1'b0, tmr_en = 1'b0, mext = 1'b0;
  logic pol = 1'b0, cnt_load = 1'b0, pin_en = 1'b0, run = 1'b0;
  tpc_pkg::tpc_mode_t mode = tpc_pkg::TPC_MODE_PWM;
  logic [2:0] sel = 3'h0;
  logic [15:0] ld_val = 16'h0001, rl_val = 16'h0002, pw_val = 16'h0001;
  logic [15:0] frz;
  logic [7:0] db = 8'h02;
  logic cmp_out, tmr_irq, tmr_out, out_oe, tmr_out_n, out_n_oe, in_is_n, lv;
  logic seen;
  logic [15:0] timer_count;
  int miscompares = 0, total_checks = 0, n, gap, op;
  initial forever #2 core_clk = ~core_clk;
  tpc_cmp_src tpc_cmp_src_inst (.core_clk(core_clk), .run(run),
    .cmp_out(cmp_out));
  tpc_timer tpc_timer_inst (.core_clk(core_clk), .rst_n(rst_n),
    .tmr_en(tmr_en), .mode_sel(mode), .timer_mode_extension_bit(mext),
    .output_polarity_select(pol), .prescale_sel(sel), .cnt_load(cnt_load),
    .cnt_load_val(ld_val), .reload_val(rl_val), .pwm_val(pw_val),
    .deadband(db), .out_pin_en(pin_en), .cmp_out(cmp_out),
    .timer_count(timer_count), .tmr_irq(tmr_irq), .tmr_out(tmr_out),
    .tmr_out_oe(out_oe), .tmr_out_n(tmr_out_n), .tmr_out_n_oe(out_n_oe),
    .tmr_in_is_out_n(in_is_n));
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic stop_test;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  // seen flags any cycle where the output left its initial level
  task automatic wait_irq;
    n = 0;
    seen = 1'b0;
    do begin
      tick(1);
      n++;
      if (tmr_out !== pol) seen = 1'b1;
    end while (tmr_irq !== 1'b1 && n < 3000);
    if (n >= 3000) miscompares++;
  endtask : wait_irq
  task automatic setup(input tpc_pkg::tpc_mode_t m, input logic x,
      input logic p, input logic [2:0] s, input logic [15:0] pw, rl);
    tmr_en = 1'b0;
    mode = m;
    mext = x;
    pol = p;
    sel = s;
    pw_val = pw;
    rl_val = rl;
    cnt_load = 1'b1;
    tick(1);
    cnt_load = 1'b0;
    tick(1);
  endtask : setup
  initial begin
    #200000;
    miscompares++;
    stop_test();
  end
  initial begin
    tick(20);
    rst_n = 1'b1;
    tick(1);
    `CHK("count rst", 16'h0000, timer_count);
    `CHK("irq rst", 1'b0, tmr_irq);
    foreach (rows[i]) begin
      setup(tpc_pkg::TPC_MODE_PWM, 1'b0, rows[i].pol, rows[i].sel,
        rows[i].pw, rows[i].rl);
      tmr_en = 1'b1;
      wait_irq();
      wait_irq();
      `CHK("period", rows[i].rl << rows[i].sel, n);
      `CHK("count", 16'h0001, timer_count);
      `CHK("out rl", rows[i].pol, tmr_out);
      `CHK("toggle", 1'b1, seen);
    end
    // prescale 3 must be ignored while counting comparator edges
    setup(tpc_pkg::TPC_MODE_CMP_CNT, 1'b0, 1'b1, 3'h3, 16'h0000, 16'h0004);
    pin_en = 1'b1;
    tick(1);
    `CHK("cmp init", 1'b1, tmr_out);
    `CHK("oe", 1'b1, out_oe);
    tmr_en = 1'b1;
    run = 1'b1;
    wait_irq();
    lv = tmr_out;
    wait_irq();
    `CHK("cmp period", 24, n);
    `CHK("cmp count", 16'h0001, timer_count);
    `CHK("cmp out", ~lv, tmr_out);
    tmr_en = 1'b0;
    tick(2);
    frz = timer_count;
    tick(10);
    `CHK("frozen", frz, timer_count);
    run = 1'b0;
    setup(tpc_pkg::TPC_MODE_PWM, 1'b1, 1'b0, 3'h0, 16'h0008, 16'h0010);
    tick(8);
    `CHK("pin swap", 1'b1, in_is_n);
    `CHK("n oe", 1'b1, out_n_oe);
    `CHK("n idle", 1'b1, tmr_out_n);
    tmr_en = 1'b1;
    wait_irq();
    gap = 0;
    op = 0;
    repeat (32) begin
      tick(1);
      if (tmr_out === 1'b0 && tmr_out_n === 1'b0) gap++;
      if (tmr_out_n === ~tmr_out) op++;
    end
    `CHK("gap", 8, gap);
    `CHK("compl", 24, op);
    wait_irq();
    `CHK("dual period", 16, n);
    // start at the top, FFFFH, so the first step rolls over
    ld_val = 16'hffff;
    setup(tpc_pkg::TPC_MODE_PWM, 1'b0, 1'b0, 3'h0, 16'h0002, 16'h0003);
    tmr_en = 1'b1;
    tick(1);
    `CHK("wrap", 16'h0000, timer_count);
    tick(1);
    `CHK("after wrap", 16'h0001, timer_count);
    stop_test();
  end
endmodule : tb

/* File: tpc_cmp_src.sv */
// comparator output source for the timer bench
`timescale 1ns/10ps
module tpc_cmp_src #(
  parameter int HALF = 3
) (
  input wire logic core_clk,
  input wire logic run,
  output logic cmp_out
);
  int cnt = 0;
  initial cmp_out = 1'b0;
  // never faster than a quarter clock, or edges get lost
  always @(posedge core_clk) begin
    if (run) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) cmp_out <= ~cmp_out;
    end
  end
endmodule : tpc_cmp_src

/* File: tpc_dead_if.sv */
// link between the timer core and its deadband stage
`timescale 1ns/10ps
interface tpc_dead_if;
  logic raw;
  logic [7:0] deadband;
  logic pos;
  logic neg;
  modport ctrl (output raw, output deadband, input pos, input neg);
  modport dead (input raw, input deadband, output pos, output neg);
endinterface : tpc_dead_if

/* File: tpc_deadband.sv */
// deadband stage: delays only the rising edge of each pwm output
`timescale 1ns/10ps
`include "tpc_map.svh"
module tpc_deadband (
  input wire logic core_clk,
  input wire logic rst_n,
  tpc_dead_if.dead db
);
  logic prev_q, prev_d;
  logic [`TPC_DB_W-1:0] age_q, age_d;
  logic pos_q, pos_d;
  logic neg_q, neg_d;

  always_comb begin
    prev_d = db.raw;
    // age saturates so a long phase never wraps back into the gap
    if (db.raw != prev_q) begin
      age_d = '0;
    end else if (age_q == `TPC_DB_SAT) begin
      age_d = age_q;
    end else begin
      age_d = age_q + `TPC_DB_W'(1);
    end
    pos_d = db.raw && (age_d >= db.deadband); // R17
    neg_d = !db.raw && (age_d >= db.deadband); // R16
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
      age_q <= '0;
      pos_q <= 1'b0;
      neg_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      age_q <= age_d;
      pos_q <= pos_d;
      neg_q <= neg_d;
    end
  end

  assign db.pos = pos_q;
  assign db.neg = neg_q;

  a_dead_no_overlap: assert property ( // R17
    @(posedge core_clk) disable iff (!rst_n) !(pos_q && neg_q))
    else $error("both pwm outputs high");
  a_dead_fall_fast: assert property ( // R17
    @(posedge core_clk) disable iff (!rst_n) $fell(db.raw) |=> !pos_q)
    else $error("falling edge was delayed");
endmodule : tpc_deadband

/* File: tpc_map.svh */
// constants for the comparator-counter and pwm timer
`ifndef TPC_MAP_SVH
`define TPC_MAP_SVH
`define TPC_CNT_W 16
`define TPC_CNT_RESTART 16'h0001
`define TPC_CNT_WRAP 16'h0000
`define TPC_CNT_RST 16'h0000
`define TPC_PRESC_W 7
`define TPC_PRESC_SEL_W 3
`define TPC_DB_W 8
`define TPC_DB_MAX 8'h80
`define TPC_DB_SAT 8'hff
`endif

/* File: tpc_pkg.sv */
// types shared by the timer modules
package tpc_pkg;
  typedef enum logic [0:0] {
    TPC_MODE_CMP_CNT,
    TPC_MODE_PWM
  } tpc_mode_t;
endpackage : tpc_pkg

/* File: tpc_timer.sv */
// reloadable timer: comparator-counter, single and dual pwm modes
//
// Overview of operation
// [R1] comparator mode counts each selected comparator edge; polarity bit picks it
// [R2] comparator mode bypasses the prescaler, one count per edge
// [R3] comparator output must toggle no faster than a quarter clock
// [R4] at reload in comparator mode: interrupt, count to 0001H, keep going
// [R5] comparator mode with output enabled toggles the output at each reload
// [R6] comparator mode start count only affects the first pass
// [R7] software normally preloads 0001H; transitions equal count minus start
// [R8] software disables, sets mode and edge, loads counts, then enables
// [R9] edge selection also sets initial output level
// [R10] single pwm toggles at match, interrupt and 0001H at reload
// [R11] polarity one: high until match, low after, high at reload
// [R12] polarity zero: low until match, high after, low at reload
// [R13] software keeps reload above the pwm match value
// [R14] pwm start count only governs the first period
// [R15] pwm period is reload times prescale clocks
// [R16] dual pwm drives the signal and its complement
// [R17] dual pwm delays only rising edges by 0 to 128 clocks; deadband is not clamped, so delays go up to 255
// [R18] dual mode needs the mode extension bit as well
// [R19] software keeps deadband shorter than both pwm phases
// [R20] software writes the deadband before enabling dual mode
// [R21] dual mode turns the timer input pin into complement output
// [R22] software disables, configures, loads counts, then enables single pwm
// [R23] prescaler divides the clock by 1 to 128 in clocked modes
// [R24] counter wraps from FFFFH to 0000H without a reload
// [R25] disabled dual mode holds complement at inverse of initial level
// [R26] counting starts the clock after enable and freezes while disabled
`timescale 1ns/10ps
`include "tpc_map.svh"
module tpc_timer #(
  parameter int CNT_W = `TPC_CNT_W
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic tmr_en,
  input wire tpc_pkg::tpc_mode_t mode_sel,
  input wire logic timer_mode_extension_bit,
  input wire logic output_polarity_select,
  input wire logic [`TPC_PRESC_SEL_W-1:0] prescale_sel,
  input wire logic cnt_load,
  input wire logic [CNT_W-1:0] cnt_load_val,
  input wire logic [CNT_W-1:0] reload_val,
  input wire logic [CNT_W-1:0] pwm_val,
  input wire logic [`TPC_DB_W-1:0] deadband,
  input wire logic out_pin_en,
  input wire logic cmp_out,
  output logic [CNT_W-1:0] timer_count,
  output logic tmr_irq,
  output logic tmr_out,
  output logic tmr_out_oe,
  output logic tmr_out_n,
  output logic tmr_out_n_oe,
  output logic tmr_in_is_out_n
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [`TPC_PRESC_W-1:0] presc_lim(
    input logic [`TPC_PRESC_SEL_W-1:0] sel);
    presc_lim = `TPC_PRESC_W'((8'h01 << sel) - 8'h01);
  endfunction : presc_lim

  tpc_dead_if dl();

  logic sync1_q, sync2_q, sync3_q;
  logic [`TPC_PRESC_W-1:0] presc_q, presc_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic lvl_q, lvl_d;
  logic irq_q, irq_d;
  logic cmp_mode, dual_mode, cmp_edge, tick, at_reload;

  // ----------------------------------------------------------------
  // comparator input: two flops, then a third for the edge
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else begin
      sync1_q <= cmp_out;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // edges closer than a quarter clock may merge here
  assign cmp_edge = output_polarity_select ? (sync2_q && !sync3_q)
                                           : (!sync2_q && sync3_q); // R1 R3

  assign cmp_mode = (mode_sel == tpc_pkg::TPC_MODE_CMP_CNT);
  assign dual_mode = (mode_sel == tpc_pkg::TPC_MODE_PWM) &&
                     timer_mode_extension_bit; // R18
  assign tick = cmp_mode ? cmp_edge
                         : (presc_q == presc_lim(prescale_sel)); // R2 R23
  assign at_reload = (cnt_q == reload_val);

  // ----------------------------------------------------------------
  // prescaler, counter and output level
  // ----------------------------------------------------------------
  always_comb begin
    if (!tmr_en || cmp_mode || tick) begin
      presc_d = '0; // R2 R23
    end else begin
      presc_d = presc_q + `TPC_PRESC_W'(1);
    end
    cnt_d = cnt_q;
    lvl_d = lvl_q;
    irq_d = 1'b0;
    if (cnt_load) begin
      cnt_d = cnt_load_val; // R6 R14
    end else if (tmr_en && tick) begin // R26
      if (at_reload) begin
        cnt_d = `TPC_CNT_RESTART; // R4 R6 R10 R14 R15
        irq_d = 1'b1; // R4 R10
        if (cmp_mode) begin
          if (out_pin_en) begin
            lvl_d = !lvl_q; // R5
          end
        end else begin
          lvl_d = output_polarity_select; // R11 R12
        end
      end else begin
        // natural overflow gives the FFFFH to 0000H wrap
        cnt_d = cnt_q + CNT_W'(1); // R1 R24
        if (!cmp_mode && cnt_d == pwm_val) begin
          lvl_d = !output_polarity_select; // R10 R11 R12
        end
      end
    end
    if (!tmr_en) begin
      lvl_d = output_polarity_select; // R9 R11 R12 R25
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_q <= '0;
      cnt_q <= `TPC_CNT_RST;
      lvl_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      presc_q <= presc_d;
      cnt_q <= cnt_d;
      lvl_q <= lvl_d;
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // deadband and pins
  // ----------------------------------------------------------------
  assign dl.raw = lvl_q;
  assign dl.deadband = deadband;

  tpc_deadband u_dead (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .db(dl.dead)
  );

  assign timer_count = cnt_q;
  assign tmr_irq = irq_q;
  assign tmr_out = dual_mode ? dl.pos : lvl_q; // R16 R17
  assign tmr_out_oe = out_pin_en;
  assign tmr_out_n = dl.neg; // R16 R25
  assign tmr_in_is_out_n = dual_mode; // R21
  assign tmr_out_n_oe = dual_mode && out_pin_en; // R21

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_reload;
    tmr_en && tick && !cnt_load && at_reload;
  endsequence

  sequence s_step;
    tmr_en && tick && !cnt_load && !at_reload;
  endsequence

  a_reload_restart: assert property ( // R4 R10
    s_reload |=> cnt_q == `TPC_CNT_RESTART && tmr_irq)
    else $error("reload did not restart at one");
  a_cmp_one_step: assert property ( // R1 R2
    (s_step and cmp_mode) |=> cnt_q == CNT_W'($past(cnt_q) + CNT_W'(1)))
    else $error("comparator edge miscounted");
  a_cmp_no_edge: assert property ( // R1 R2
    cmp_mode && !cmp_edge && !cnt_load |=> $stable(cnt_q))
    else $error("count moved without edge");
  a_freeze_off: assert property ( // R26
    !tmr_en && !cnt_load |=> $stable(cnt_q))
    else $error("count moved while disabled");
  a_wrap_zero: assert property ( // R24
    (s_step and cnt_q == {CNT_W{1'b1}}) |=> cnt_q == `TPC_CNT_WRAP)
    else $error("no wrap to zero");
  a_pwm_match: assert property ( // R11 R12
    (s_step and (!cmp_mode && CNT_W'(cnt_q + CNT_W'(1)) == pwm_val)) |=>
    lvl_q == !$past(output_polarity_select))
    else $error("pwm match level wrong");
  a_cmp_toggle: assert property ( // R5
    (s_reload and (cmp_mode && out_pin_en)) ##1 tmr_en |->
    lvl_q != $past(lvl_q))
    else $error("no toggle at reload");
  a_init_level: assert property ( // R9 R25
    !tmr_en |=> lvl_q == $past(output_polarity_select))
    else $error("initial level wrong");
  a_presc_bound: assert property ( // R23
    !cmp_mode && tmr_en |-> presc_q <= presc_lim(prescale_sel))
    else $error("prescaler overran");

  // comparator counts must never wait on a prescaler phase
  a_presc_idle: assert property ( // R2
    cmp_mode |=> presc_q == '0)
    else $error("prescaler ran in comparator mode");
  a_pwm_reload_lvl: assert property ( // R11 R12
    (s_reload and !cmp_mode) |=> lvl_q == $past(output_polarity_select))
    else $error("pwm reload level wrong");
  a_irq_at_reload: assert property ( // R4 R10
    !(tmr_en && tick && !cnt_load && at_reload) |=> !tmr_irq)
    else $error("interrupt without reload");
  a_dual_apart: assert property ( // R16 R17
    dual_mode |-> !(tmr_out && tmr_out_n))
    else $error("dual outputs overlap");
endmodule : tpc_timer
